// *** inc/shk_defs.vh ***
/*
 header of constants for the serial handshake and keying block.
 assumes a 250 MHz system clock; included by bare name.
*/
`ifndef SHK_DEFS_VH
`define SHK_DEFS_VH

`define SHK_CLK_HZ 250000000
`define SHK_TICK_HZ 1000
`define SHK_TICK_CYCLES (`SHK_CLK_HZ / `SHK_TICK_HZ)

// register byte addresses
`define SHK_A_CTRL 12'h000
`define SHK_A_CTS_DLY 12'h004
`define SHK_A_HOLD 12'h008
`define SHK_A_GAP 12'h00C
`define SHK_A_HOP 12'h010
`define SHK_A_STATUS 12'h014
`define SHK_A_PORT 12'h018
`define SHK_A_INIT 12'h01C

// ctrl fields
`define SHK_C_KEYLINE 0
`define SHK_C_RATE_LO 1
`define SHK_C_RATE_HI 3
`define SHK_C_NODE_LO 4
`define SHK_C_NODE_HI 5
`define SHK_C_MASTER 6

// status fields
`define SHK_S_CTS 0
`define SHK_S_KEY 1
`define SHK_S_TXEN 2
`define SHK_S_NEWMSG 3
`define SHK_S_SYNC 4

// diag link rate codes
`define SHK_RATE_1200 3'h0
`define SHK_RATE_2400 3'h1
`define SHK_RATE_4800 3'h2
`define SHK_RATE_9600 3'h3
`define SHK_RATE_19200 3'h4

// node types
`define SHK_NODE_NODE 2'h0
`define SHK_NODE_ROOT 2'h1
`define SHK_NODE_GATE 2'h2
`define SHK_NODE_PEER 2'h3

// hop codes
`define SHK_HOP_SHORTEST 3'h0
`define SHK_HOP_NORMAL 3'h6
`define SHK_HOP_LONG 3'h7

// port defaults: 4800 8N1, 30 dBm
`define SHK_PORT_BAUD_4800 3'h2
`define SHK_PORT_DEFAULT 16'h1E82

`define SHK_DLY_MAX 8'hFF
`define SHK_HOLD_MAX 13'h1770
`define SHK_HOLD_NA 32'hFFFF_FFFF
`define SHK_GAP_DEFAULT 8'h0A
`define SHK_INIT_KEY 32'h0000_00A5

`endif

// *** logic/shk_ms_timer.v ***
/*
 millisecond down counter loaded with a count, counting on a shared tick.
 assumes tick is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ps
module shk_ms_timer #(
    parameter W = 13
) (
    input wire clk_i,
    input wire resetn_i,
    input wire tick_i,
    input wire load_i,
    input wire [W-1:0] value_i,
    output reg busy_o,
    output wire done_o
);
    reg [W-1:0] count;
    reg busy_q;

    assign done_o = busy_q & ~busy_o;

    always @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            count <= {W{1'b0}};
            busy_o <= 1'b0;
            busy_q <= 1'b0;
        end
        else
        begin
            busy_q <= busy_o;
            if (load_i)
            begin
                count <= value_i;
                busy_o <= (value_i != {W{1'b0}});
            end
            else if (busy_o && tick_i)
            begin
                count <= count - {{(W-1){1'b0}}, 1'b1};
                busy_o <= (count != {{(W-1){1'b0}}, 1'b1});
            end
        end
    end
endmodule // shk_ms_timer

// *** logic/shk_serial_handshake.v ***
/*
 handshake and keying control of the serial data port, with its settings
 behind an apb slave. assumes rts, rx-char and rf-data strobes from
 outside are asynchronous pins/levels; char and busy strobes are on clk_i.
*/
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "shk_defs.vh"
module shk_serial_handshake #(
    parameter TICK_CYCLES = `SHK_TICK_CYCLES
) (
    input wire clk_i,
    input wire resetn_i,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire rts_i,
    input wire rf_data_avail_i,
    input wire port_char_i,
    input wire throttle_i,
    input wire out_char_i,
    input wire out_busy_i,
    input wire synced_i,
    output reg cts_o,
    output reg tx_key_o,
    output reg out_enable_o,
    output reg new_message_o,
    output wire [2:0] diag_link_rate_o,
    output wire [1:0] diag_node_type_o,
    output wire nonintrusive_ok_o,
    output wire [2:0] hop_code_o,
    output reg [7:0] dwell_ms_o,
    output reg [8:0] hop_bytes_o
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_KEYUP = 4'b0010;
    localparam ST_SEND = 4'b0100;
    localparam ST_HOLD = 4'b1000;

    function [7:0] dwell_of;
        input [2:0] code;
        begin
            case (code)
                3'h0: dwell_of = 8'h0A;
                3'h1: dwell_of = 8'h10;
                3'h2: dwell_of = 8'h14;
                3'h3: dwell_of = 8'h19;
                3'h4: dwell_of = 8'h20;
                3'h5: dwell_of = 8'h28;
                3'h6: dwell_of = 8'h50;
                default: dwell_of = 8'hA0;
            endcase
        end
    endfunction

    function [8:0] bytes_of;
        input [2:0] code;
        begin
            case (code)
                3'h0: bytes_of = 9'h009;
                3'h1: bytes_of = 9'h015;
                3'h2: bytes_of = 9'h01E;
                3'h3: bytes_of = 9'h027;
                3'h4: bytes_of = 9'h039;
                3'h5: bytes_of = 9'h048;
                3'h6: bytes_of = 9'h0A2;
                default: bytes_of = 9'h150;
            endcase
        end
    endfunction

    function rate_ok;
        input [2:0] r;
        begin
            rate_ok = (r <= `SHK_RATE_19200);
        end
    endfunction

    // settings
    reg keyline;
    reg [2:0] diag_rate;
    reg [1:0] node_type;
    reg master;
    reg [7:0] cts_dly;
    reg [12:0] hold_ms;
    reg [7:0] gap_ms;
    reg [2:0] hop_code;
    reg [15:0] port_cfg;

    // pin synchronisers
    reg [2:0] rts_s;
    reg [1:0] rf_s;
    reg [2:0] ch_s;
    wire rts = rts_s[1];
    wire rts_rise = rts_s[1] & ~rts_s[2];
    wire char_in = ch_s[1] & ~ch_s[2];

    // apb
    wire wr = psel & penable & pwrite;
    wire rd_any = psel & ~pwrite;
    wire init_hit = wr && paddr == `SHK_A_INIT && pwdata == `SHK_INIT_KEY;
    wire hop_locked = ~master & ~synced_i;
    assign pready = 1'b1;
    assign pslverr = psel & penable & (
        (paddr > `SHK_A_INIT) | (paddr[1:0] != 2'h0) |
        (pwrite & paddr == `SHK_A_HOP & ~master) |
        (~pwrite & paddr == `SHK_A_HOP & hop_locked));

    assign diag_link_rate_o = diag_rate;
    assign diag_node_type_o = node_type;
    // only the root runs passive diagnostics
    assign nonintrusive_ok_o = (node_type == `SHK_NODE_ROOT);
    assign hop_code_o = hop_code;

    // shared ms tick
    reg [31:0] tick_cnt;
    wire tick = (tick_cnt == TICK_CYCLES - 1);

    always @(posedge clk_i)
    begin
        if (!resetn_i)
            tick_cnt <= 32'h0000_0000;
        else if (tick)
            tick_cnt <= 32'h0000_0000;
        else
            tick_cnt <= tick_cnt + 32'h0000_0001;
    end

    always @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            rts_s <= 3'h0;
            rf_s <= 2'h0;
            ch_s <= 3'h0;
        end
        else
        begin
            rts_s <= {rts_s[1:0], rts_i};
            rf_s <= {rf_s[0], rf_data_avail_i};
            ch_s <= {ch_s[1:0], port_char_i};
        end
    end

    // settings registers
    always @(posedge clk_i)
    begin
        if (!resetn_i || init_hit)
        begin
            keyline <= 1'b0;
            cts_dly <= 8'h00;
            port_cfg <= `SHK_PORT_DEFAULT;
            if (!resetn_i || master)
                hop_code <= `SHK_HOP_NORMAL;
            if (!resetn_i)
            begin
                diag_rate <= `SHK_RATE_19200;
                node_type <= `SHK_NODE_NODE;
                master <= 1'b0;
                hold_ms <= 13'h0000;
                gap_ms <= `SHK_GAP_DEFAULT;
            end
        end
        else if (wr)
        begin
            case (paddr)
                `SHK_A_CTRL:
                begin
                    keyline <= pwdata[`SHK_C_KEYLINE];
                    if (rate_ok(pwdata[`SHK_C_RATE_HI:`SHK_C_RATE_LO]))
                        diag_rate <= pwdata[`SHK_C_RATE_HI:`SHK_C_RATE_LO];
                    node_type <= pwdata[`SHK_C_NODE_HI:`SHK_C_NODE_LO];
                    master <= pwdata[`SHK_C_MASTER];
                end
                `SHK_A_CTS_DLY: cts_dly <= pwdata[7:0];
                `SHK_A_HOLD:
                    // clamp to 6000 ms, ignored in terminal mode
                    if (keyline)
                        hold_ms <= (pwdata[31:13] != 19'h0 ||
                            pwdata[12:0] > `SHK_HOLD_MAX) ? `SHK_HOLD_MAX : pwdata[12:0];
                `SHK_A_GAP: gap_ms <= pwdata[7:0];
                `SHK_A_HOP:
                    if (master)
                        hop_code <= pwdata[2:0];
                `SHK_A_PORT: port_cfg <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // dwell and byte limit per code
    always @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            dwell_ms_o <= dwell_of(`SHK_HOP_NORMAL);
            hop_bytes_o <= bytes_of(`SHK_HOP_NORMAL);
        end
        else
        begin
            dwell_ms_o <= dwell_of(hop_code);
            hop_bytes_o <= bytes_of(hop_code);
        end
    end

    // timers
    wire dly_load;
    wire dly_busy;
    wire dly_done;
    wire hold_load;
    wire hold_busy;
    wire hold_done;
    wire gap_busy;

    shk_ms_timer #(.W(13)) u_dly (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .tick_i(tick),
        .load_i(dly_load),
        .value_i({5'h00, cts_dly}),
        .busy_o(dly_busy),
        .done_o(dly_done)
    );

    shk_ms_timer #(.W(13)) u_hold (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .tick_i(tick),
        .load_i(hold_load),
        .value_i(hold_ms),
        .busy_o(hold_busy),
        .done_o(hold_done)
    );

    shk_ms_timer #(.W(13)) u_gap (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .tick_i(tick),
        .load_i(char_in),
        .value_i({5'h00, gap_ms}),
        .busy_o(gap_busy),
        .done_o()
    );

    // terminal-mode cts path
    reg dte_ready;
    reg [3:0] state;
    reg [3:0] next_state;
    assign dly_load = keyline ? (state == ST_IDLE && rf_s[1]) : rts_rise;

    always @(posedge clk_i)
    begin
        if (!resetn_i)
            dte_ready <= 1'b0;
        else if (!rts)
            dte_ready <= 1'b0;
        else if (rts_rise ? cts_dly == 8'h00 : (dly_done | (~dly_busy & dte_ready)))
            dte_ready <= 1'b1;
    end

    // keyline state machine
    assign hold_load = (state == ST_SEND) && !rf_s[1] && !out_busy_i;

    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (keyline && rf_s[1])
                    next_state = (cts_dly == 8'h00) ? ST_SEND : ST_KEYUP;
            ST_KEYUP:
                if (dly_done)
                    next_state = ST_SEND;
            ST_SEND:
                if (hold_load)
                    next_state = ST_HOLD;
            ST_HOLD:
                if (rf_s[1])
                    next_state = ST_SEND;
                else if (!hold_busy || hold_done)
                    next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
        if (!keyline)
            next_state = ST_IDLE;
    end

    always @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            state <= ST_IDLE;
            cts_o <= 1'b0;
            tx_key_o <= 1'b0;
            out_enable_o <= 1'b0;
            new_message_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            new_message_o <= char_in & ~gap_busy;
            if (keyline)
            begin
                cts_o <= (next_state != ST_IDLE);
                out_enable_o <= (next_state == ST_SEND) || (next_state == ST_HOLD);
                tx_key_o <= 1'b0;
            end
            else
            begin
                // zero delay always on, throttle drops
                cts_o <= ((cts_dly == 8'h00) | dte_ready) & ~throttle_i;
                out_enable_o <= 1'b1;
                tx_key_o <= char_in | (tx_key_o & gap_busy);
            end
        end
    end

    // apb read data
    always @*
    begin
        prdata = 32'h0000_0000;
        if (rd_any)
        begin
            case (paddr)
                `SHK_A_CTRL: prdata = {25'h0, master, node_type, diag_rate, keyline};
                `SHK_A_CTS_DLY: prdata = {24'h0, cts_dly};
                `SHK_A_HOLD: prdata = keyline ? {19'h0, hold_ms} : `SHK_HOLD_NA;
                `SHK_A_GAP: prdata = {24'h0, gap_ms};
                `SHK_A_HOP: prdata = hop_locked ? 32'h0 : {29'h0, hop_code};
                `SHK_A_STATUS: prdata = {27'h0, synced_i, new_message_o,
                    out_enable_o, tx_key_o, cts_o};
                `SHK_A_PORT: prdata = {16'h0, port_cfg};
                default: prdata = 32'h0000_0000;
            endcase
        end
    end
endmodule // shk_serial_handshake

// *** verification/shk_hs_properties.sv ***
/*
 port checker for shk_serial_handshake.
 assumes a bind onto that module and the shk defs header.
*/
`timescale 1ns/1ps
`include "shk_defs.vh"
module shk_hs_props (
    input wire clk_i,
    input wire resetn_i,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire rts_i,
    input wire rf_data_avail_i,
    input wire throttle_i,
    input wire cts_o,
    input wire out_enable_o,
    input wire [2:0] diag_link_rate_o,
    input wire [1:0] diag_node_type_o,
    input wire nonintrusive_ok_o,
    input wire [2:0] hop_code_o,
    input wire [7:0] dwell_ms_o,
    input wire [8:0] hop_bytes_o
);
    // shadow of mode, master and delay, kept from bus writes
    reg kl;
    reg ms;
    reg [7:0] dly;
    wire wr = psel && penable && pwrite;
    wire init = wr && paddr == `SHK_A_INIT && pwdata == `SHK_INIT_KEY;
    always @(posedge clk_i)
    begin
        if (!resetn_i || init)
            kl <= 1'b0;
        else if (wr && paddr == `SHK_A_CTRL)
            kl <= pwdata[0];
    end
    always @(posedge clk_i)
    begin
        if (!resetn_i)
            ms <= 1'b0;
        else if (wr && paddr == `SHK_A_CTRL)
            ms <= pwdata[6];
    end
    always @(posedge clk_i)
    begin
        if (!resetn_i || init)
            dly <= 8'h00;
        else if (wr && paddr == `SHK_A_CTS_DLY)
            dly <= pwdata[7:0];
    end
    function [16:0] hop_tbl(input [2:0] c);
        case (c)
            3'h0: hop_tbl = {8'h0A, 9'h009};
            3'h1: hop_tbl = {8'h10, 9'h015};
            3'h2: hop_tbl = {8'h14, 9'h01E};
            3'h3: hop_tbl = {8'h19, 9'h027};
            3'h4: hop_tbl = {8'h20, 9'h039};
            3'h5: hop_tbl = {8'h28, 9'h048};
            3'h6: hop_tbl = {8'h50, 9'h0A2};
            default: hop_tbl = {8'hA0, 9'h150};
        endcase
    endfunction
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // three cycles of margin cover the registered cts path
    property p_zero_dly;
        (!kl && dly == 8'h00 && !throttle_i) [*3] |-> cts_o;
    endproperty
    a_zero_dly: assert property (p_zero_dly)
        else $error("cts low at zero delay");
    property p_rts_low;
        (!kl && dly != 8'h00 && !rts_i) [*6] |-> !cts_o;
    endproperty
    a_rts_low: assert property (p_rts_low)
        else $error("cts high without rts");
    property p_throttle;
        (!kl && throttle_i) [*2] |-> !cts_o;
    endproperty
    a_throttle: assert property (p_throttle)
        else $error("cts high while throttled");
    property p_rf_key;
        kl && $rose(rf_data_avail_i) |-> ##[1:5] cts_o;
    endproperty
    a_rf_key: assert property (p_rf_key)
        else $error("cts late on rf data");
    property p_keyup;
        kl && dly != 8'h00 && $rose(cts_o) |-> !out_enable_o;
    endproperty
    a_keyup: assert property (p_keyup)
        else $error("data before key-up delay");
    property p_rate;
        diag_link_rate_o <= `SHK_RATE_19200;
    endproperty
    a_rate: assert property (p_rate)
        else $error("bad link rate code");
    property p_root;
        nonintrusive_ok_o == (diag_node_type_o == `SHK_NODE_ROOT);
    endproperty
    a_root: assert property (p_root)
        else $error("non-intrusive flag wrong");
    property p_dwell;
        $stable(hop_code_o) [*2] |-> {dwell_ms_o, hop_bytes_o} == hop_tbl(hop_code_o);
    endproperty
    a_dwell: assert property (p_dwell)
        else $error("dwell lookup wrong");
    property p_hop_ro;
        wr && paddr == `SHK_A_HOP && !ms |-> pslverr;
    endproperty
    a_hop_ro: assert property (p_hop_ro)
        else $error("hop write accepted off master");
    property p_hold_na;
        psel && !pwrite && paddr == `SHK_A_HOLD && !kl |-> prdata == `SHK_HOLD_NA;
    endproperty
    a_hold_na: assert property (p_hold_na)
        else $error("hold read not n/a");
endmodule // shk_hs_props

bind shk_serial_handshake shk_hs_props shk_hs_props_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .rts_i(rts_i), .rf_data_avail_i(rf_data_avail_i),
    .throttle_i(throttle_i), .cts_o(cts_o), .out_enable_o(out_enable_o),
    .diag_link_rate_o(diag_link_rate_o), .diag_node_type_o(diag_node_type_o),
    .nonintrusive_ok_o(nonintrusive_ok_o), .hop_code_o(hop_code_o),
    .dwell_ms_o(dwell_ms_o), .hop_bytes_o(hop_bytes_o)
);

// *** verification/shk_dte_model.sv ***
/*
 terminal equipment on the data port: raises rts when told to send,
 sends characters only while cleared. assumes the dut clock.
*/
`timescale 1ns/1ps
module shk_dte_model (
    input wire clk_i,
    input wire send_i,
    input wire cts_i,
    output reg rts_o,
    output reg char_o
);
    reg [2:0] phase;
    initial
    begin
        rts_o = 1'b0;
        char_o = 1'b0;
        phase = 3'h0;
    end
    always @(posedge clk_i)
    begin
        rts_o <= send_i;
        phase <= phase + 3'h1;
        // one char per 8 cycles, only while cleared
        char_o <= send_i && rts_o && cts_i && phase[2];
    end
endmodule // shk_dte_model

// *** verification/tb_shk_serial_handshake.sv ***
/*
 self-checking bench for shk_serial_handshake over apb.
 assumes the defs header and a 10-cycle millisecond tick.
*/
`timescale 1ns/1ps
`include "shk_defs.vh"
module tb_shk_serial_handshake;
    reg clk_i = 1'b0;
    reg resetn_i = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    reg rf = 1'b0;
    reg throttle = 1'b0;
    reg busy = 1'b0;
    reg synced = 1'b1;
    reg send = 1'b0;
    wire [31:0] prdata;
    wire pready, pslverr, rts, pchar, cts_o, tx_key_o, out_enable_o, nonintrusive_ok_o;
    wire [2:0] hop_code_o;
    wire [7:0] dwell_ms_o;
    wire [8:0] hop_bytes_o;
    wire [2:0] mon = {tx_key_o, out_enable_o, cts_o};
    wire nmsg;
    reg saw_nmsg = 1'b0;
    reg [31:0] rdat;
    reg rerr;
    integer n_fail = 0;
    integer checks_done = 0;
    integer i;
    always #2 clk_i = ~clk_i;
    // new-message is a one-cycle pulse, so latch it for a later look
    always @(posedge clk_i)
        if (nmsg)
            saw_nmsg <= 1'b1;
    shk_dte_model shk_dte_model_i (.clk_i(clk_i), .send_i(send), .cts_i(cts_o),
        .rts_o(rts), .char_o(pchar));
    shk_serial_handshake #(.TICK_CYCLES(10)) shk_serial_handshake_i (
        .clk_i(clk_i), .resetn_i(resetn_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rts_i(rts), .rf_data_avail_i(rf),
        .port_char_i(pchar), .throttle_i(throttle), .out_char_i(1'b0),
        .out_busy_i(busy), .synced_i(synced), .cts_o(cts_o), .tx_key_o(tx_key_o),
        .out_enable_o(out_enable_o), .new_message_o(nmsg), .diag_link_rate_o(),
        .diag_node_type_o(), .nonintrusive_ok_o(nonintrusive_ok_o),
        .hop_code_o(hop_code_o), .dwell_ms_o(dwell_ms_o), .hop_bytes_o(hop_bytes_o));
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp)
            begin
                n_fail = n_fail + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge clk_i);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk_i);
            penable <= 1'b1;
            @(posedge clk_i);
            while (pready !== 1'b1)
                @(posedge clk_i);
            rdat = prdata;
            rerr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // waits bounded for one monitored output, then compares it
    task wait_sig(input [1:0] s, input v, input integer n);
        integer k;
        begin
            k = 0;
            while (mon[s] !== v && k < n)
            begin
                @(posedge clk_i);
                k = k + 1;
            end
            chk(mon[s], v);
        end
    endtask
    task give_verdict;
        begin
            if (n_fail == 0 && checks_done > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial
    begin
        #40000;
        n_fail = n_fail + 1;
        give_verdict;
    end
    initial
    begin
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        apb(0, `SHK_A_CTRL, 0);
        chk(rdat, 32'h8);
        apb(0, `SHK_A_HOP, 0);
        chk(rdat, 32'h6);
        chk({dwell_ms_o, hop_bytes_o}, {8'h50, 9'h0A2});
        apb(0, `SHK_A_HOLD, 0);
        chk(rdat, `SHK_HOLD_NA);
        apb(0, 12'h040, 0);
        chk(rerr, 1);
        chk(rdat, 0);
        chk(cts_o, 1);
        throttle <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk(cts_o, 0);
        throttle <= 1'b0;
        wait_sig(0, 1, 4);
        apb(1, `SHK_A_CTS_DLY, 32'hFF);
        apb(0, `SHK_A_CTS_DLY, 0);
        chk(rdat, 32'hFF);
        apb(1, `SHK_A_CTS_DLY, 3);
        send <= 1'b1;
        repeat (12) @(posedge clk_i);
        chk(mon, 3'h2);
        wait_sig(0, 1, 50);
        wait_sig(2, 1, 40);
        send <= 1'b0;
        wait_sig(0, 0, 8);
        chk(saw_nmsg, 1);
        apb(1, `SHK_A_CTS_DLY, 2);
        apb(1, `SHK_A_CTRL, 32'h9);
        apb(1, `SHK_A_HOLD, 5);
        apb(0, `SHK_A_HOLD, 0);
        chk(rdat, 32'h5);
        rf <= 1'b1;
        wait_sig(0, 1, 6);
        chk(out_enable_o, 0);
        wait_sig(1, 1, 40);
        rf <= 1'b0;
        busy <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk(cts_o, 1);
        busy <= 1'b0;
        repeat (30) @(posedge clk_i);
        chk(cts_o, 1);
        wait_sig(0, 0, 40);
        apb(1, `SHK_A_HOLD, 0);
        rf <= 1'b1;
        wait_sig(0, 1, 6);
        wait_sig(1, 1, 40);
        rf <= 1'b0;
        wait_sig(0, 0, 8);
        send <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk(cts_o, 0);
        send <= 1'b0;
        for (i = 0; i < 6; i = i + 1)
        begin
            apb(1, `SHK_A_CTRL, i << 1);
            apb(0, `SHK_A_CTRL, 0);
            chk(rdat, (i > 4 ? 4 : i) << 1);
        end
        apb(1, `SHK_A_CTRL, 32'h18);
        repeat (2) @(posedge clk_i);
        chk(nonintrusive_ok_o, 1);
        apb(1, `SHK_A_HOP, 7);
        chk(rerr, 1);
        apb(1, `SHK_A_CTRL, 32'h48);
        for (i = 0; i < 8; i = i + 1)
            apb(1, `SHK_A_HOP, i);
        repeat (2) @(posedge clk_i);
        chk({dwell_ms_o, hop_bytes_o}, {8'hA0, 9'h150});
        apb(1, `SHK_A_HOP, `SHK_HOP_SHORTEST);
        repeat (2) @(posedge clk_i);
        chk({dwell_ms_o, hop_bytes_o}, {8'h0A, 9'h009});
        apb(1, `SHK_A_INIT, `SHK_INIT_KEY);
        apb(0, `SHK_A_HOP, 0);
        chk(rdat, 32'h6);
        apb(0, `SHK_A_CTS_DLY, 0);
        chk(rdat, 32'h0);
        apb(0, `SHK_A_PORT, 0);
        chk(rdat, `SHK_PORT_DEFAULT);
        apb(0, `SHK_A_CTRL, 0);
        chk(rdat, 32'h48);
        apb(0, `SHK_A_STATUS, 0);
        chk(rdat, 32'h15);
        apb(1, `SHK_A_CTRL, 32'h8);
        synced <= 1'b0;
        apb(0, `SHK_A_HOP, 0);
        chk(rerr, 1);
        give_verdict;
    end
endmodule // tb_shk_serial_handshake
